// ### bench/scale_command_executor_tb.sv
/*
 Self-checking bench of the scale command executor: random commands on
 both host ports, display timing and tare/inspection counters.
 Assumes sce_pkg, sce_consts.svh and the host model on the include path.
*/
`timescale 1ns/1ps
`include "sce_consts.svh"

module scale_command_executor_tb
   import sce_pkg::*;
;
   localparam int HOLD = 20;
   localparam int STEP = 12;

   typedef struct packed {
      sce_rsp_t rsp;
      sce_act_t act;
   } sce_exp_t;

   logic clk_sys;
   logic rst;
   sce_cmd_t host_cmd [`SCE_NUM_HOSTS];
   sce_rsp_t host_rsp [`SCE_NUM_HOSTS];
   logic cycle_running;
   logic automatic_totalizing_mode;
   logic emptying;
   logic cont_start;
   logic tare_done;
   logic insp_done;
   logic reg_optimal;
   sce_act_t act_q;
   logic tare_due_q;
   logic insp_due_q;
   sce_disp_t disp_q;
   sce_exp_t exp_q [2][$];
   sce_exp_t e;
   logic any;
   int err_total;
   int check_count;
   int i;
   int k;
   int g0;
   int g1;
   logic [7:0] c0;
   logic [7:0] c1;
   logic [7:0] codes [14] = '{`SCE_CMD_DEL_STATS, `SCE_CMD_SHOW_TOTAL, `SCE_CMD_EMPTY_OFF,
      `SCE_CMD_SINGLE_START, `SCE_CMD_FORCE_TARE, `SCE_CMD_FORCE_INSP, `SCE_CMD_RESID_EMPTY,
      `SCE_CMD_SHOW_WEIGHT, `SCE_CMD_SHOW_LOG, `SCE_CMD_FINISH_NO_EMPTY, 8'h73, 8'h77, 8'h78, 8'h80};

   sce_cmd_exec #(.TOTAL_HOLD_CYC(HOLD), .LOG_STEP_CYC(STEP)) i_dut (
      .clk_sys(clk_sys), .rst(rst), .host_cmd(host_cmd), .host_rsp(host_rsp),
      .cycle_running(cycle_running), .automatic_totalizing_mode(automatic_totalizing_mode),
      .emptying(emptying), .cont_start(cont_start), .tare_done(tare_done), .insp_done(insp_done),
      .reg_optimal(reg_optimal), .act_q(act_q), .tare_due_q(tare_due_q), .insp_due_q(insp_due_q),
      .disp_q(disp_q)
   );
   sce_host_model i_h0 (.clk_sys(clk_sys), .cmd(host_cmd[0]), .rsp(host_rsp[0]));
   sce_host_model i_h1 (.clk_sys(clk_sys), .cmd(host_cmd[1]), .rsp(host_rsp[1]));

   // ---------------------------------------------------------------
   // Checking and closing
   // ---------------------------------------------------------------
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         err_total++;
         $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
      end
   endtask : check

   task automatic conclude;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : conclude

   function automatic sce_exp_t expect_of(input logic [7:0] c, input logic cyc, input logic atm,
                                          input logic emp);
      sce_exp_t r;
      logic ok;
      case (c)
         `SCE_CMD_DEL_STATS: ok = !cyc;
         `SCE_CMD_EMPTY_OFF: ok = !cyc;
         `SCE_CMD_SINGLE_START: ok = !cyc;
         `SCE_CMD_RESID_EMPTY: ok = cyc;
         `SCE_CMD_FINISH_NO_EMPTY: ok = (cyc && atm) || emp;
         `SCE_CMD_SHOW_TOTAL, `SCE_CMD_SHOW_WEIGHT: ok = 1'b1;
         `SCE_CMD_SHOW_LOG, `SCE_CMD_FORCE_TARE, `SCE_CMD_FORCE_INSP: ok = 1'b1;
         default: ok = 1'b0;
      endcase
      r.rsp.ack = ok;
      r.rsp.err = !ok;
      r.act.clr_stats = ok && (c == `SCE_CMD_DEL_STATS);
      r.act.empty_off = ok && (c == `SCE_CMD_EMPTY_OFF);
      r.act.single_start = ok && (c == `SCE_CMD_SINGLE_START);
      r.act.resid_empty = ok && (c == `SCE_CMD_RESID_EMPTY);
      r.act.finish_no_empty = ok && (c == `SCE_CMD_FINISH_NO_EMPTY);
      return r;
   endfunction : expect_of

   // Responses are judged at the falling edge, after the registers settle
   always @(negedge clk_sys)
   begin
      if (!rst)
      begin
         any = 1'b0;
         for (int p = 0; p < 2; p++)
         begin
            if (host_rsp[p].ack === 1'b1 || host_rsp[p].err === 1'b1)
            begin
               any = 1'b1;
               if (exp_q[p].size() == 0)
                  check("note count", 8'h00, 8'h01);
               else
               begin
                  e = exp_q[p].pop_front();
                  check("response", 8'(host_rsp[p]), 8'(e.rsp));
                  check("action", 8'(act_q), 8'(e.act));
               end
            end
         end
         if (!any)
            check("idle action", 8'(act_q), 8'h00);
      end
   end

   // ---------------------------------------------------------------
   // Drivers
   // ---------------------------------------------------------------
   task automatic send(input int p, input logic [7:0] c, input int gap);
      logic ok;
      exp_q[p].push_back(expect_of(c, cycle_running, automatic_totalizing_mode, emptying));
      if (p == 0)
         i_h0.issue(c, gap, ok);
      else
         i_h1.issue(c, gap, ok);
      if (!ok)
      begin
         err_total++;
         $display("unexpected silence on port %0d", p);
         conclude();
      end
   endtask : send

   task automatic strobe(ref logic s, input int n);
      repeat (n)
      begin
         s = 1'b1;
         @(negedge clk_sys);
         s = 1'b0;
         @(negedge clk_sys);
      end
   endtask : strobe

   task automatic do_reset;
      rst = 1'b1;
      repeat (16) @(negedge clk_sys);
      rst = 1'b0;
      check("reset response", 8'({host_rsp[0], host_rsp[1]}), 8'h00);
      check("reset action", 8'(act_q), 8'h00);
      check("reset dues", {6'h00, tare_due_q, insp_due_q}, 8'h00);
      check("reset display", 8'(disp_q), 8'(DISP_WEIGHT));
   endtask : do_reset

   // ---------------------------------------------------------------
   // Clock, watchdog and main sequence
   // ---------------------------------------------------------------
   initial
   begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   initial
   begin
      repeat (100000) @(posedge clk_sys);
      err_total++;
      conclude();
   end

   initial
   begin
      {rst, cycle_running, automatic_totalizing_mode, emptying} = 4'h8;
      {cont_start, tare_done, insp_done, reg_optimal} = 4'h0;
      void'($urandom(32'h84B9));
      do_reset();
      // Both ports at once, random states and codes, some unknown
      for (i = 0; i < 48; i++)
      begin
         {cycle_running, automatic_totalizing_mode, emptying} = 3'($urandom);
         c0 = codes[$urandom % 14];
         c1 = codes[$urandom % 14];
         g0 = $urandom % 2;
         g1 = $urandom % 2;
         fork
            send(0, c0, g0);
            send(1, c1, g1);
         join
      end
      {cycle_running, automatic_totalizing_mode, emptying} = 3'h0;
      $display("test command table done");

      do_reset();
      send(1, `SCE_CMD_SHOW_TOTAL, 0);
      check("display", 8'(disp_q), 8'(DISP_TOTAL1));
      repeat (HOLD - 3) @(negedge clk_sys);
      check("display", 8'(disp_q), 8'(DISP_TOTAL1));
      repeat (6) @(negedge clk_sys);
      check("display", 8'(disp_q), 8'(DISP_WEIGHT));
      automatic_totalizing_mode = 1'b1;
      send(0, `SCE_CMD_SHOW_TOTAL, 0);
      repeat (3 * HOLD) @(negedge clk_sys);
      check("display", 8'(disp_q), 8'(DISP_TOTAL1));
      send(1, `SCE_CMD_SHOW_WEIGHT, 0);
      check("display", 8'(disp_q), 8'(DISP_WEIGHT));
      automatic_totalizing_mode = 1'b0;
      send(0, `SCE_CMD_SHOW_LOG, 0);
      check("display", 8'(disp_q), 8'(DISP_LOG_ID));
      // Sample each log step in its middle, then the restored value
      repeat (STEP / 2) @(negedge clk_sys);
      for (k = 0; k < 6; k++)
      begin
         check("log step", 8'(disp_q), (k < 5) ? 8'(DISP_LOG_ID) + 8'(k) : 8'(DISP_WEIGHT));
         repeat (STEP) @(negedge clk_sys);
      end
      $display("test display done");

      do_reset();
      strobe(cont_start, 9);
      check("tare due", 8'(tare_due_q), 8'h00);
      send(0, `SCE_CMD_SINGLE_START, 0);
      repeat (3) @(negedge clk_sys);
      check("tare due", 8'(tare_due_q), 8'h01);
      strobe(tare_done, 1);
      check("tare due", 8'(tare_due_q), 8'h00);
      strobe(cont_start, 10);
      check("dues", {6'h00, tare_due_q, insp_due_q}, 8'h03);
      strobe(insp_done, 1);
      check("insp due", 8'(insp_due_q), 8'h00);
      strobe(cont_start, 20);
      check("insp due", 8'(insp_due_q), 8'h00);
      strobe(reg_optimal, 1);
      strobe(cont_start, 20);
      check("insp due", 8'(insp_due_q), 8'h01);
      strobe(tare_done, 1);
      strobe(insp_done, 1);
      check("dues", {6'h00, tare_due_q, insp_due_q}, 8'h00);
      send(1, `SCE_CMD_FORCE_TARE, 0);
      repeat (3) @(negedge clk_sys);
      check("tare due", 8'(tare_due_q), 8'h01);
      send(0, `SCE_CMD_FORCE_INSP, 0);
      repeat (3) @(negedge clk_sys);
      check("insp due", 8'(insp_due_q), 8'h01);
      strobe(tare_done, 1);
      check("tare due", 8'(tare_due_q), 8'h00);
      $display("test counters done");
      conclude();
   end

endmodule : scale_command_executor_tb

// ### bench/sce_host_model.sv
/*
 Host-side model of one command port of the scale command executor.
 Assumes sce_pkg and a caller that enters issue() at a falling clock edge.
*/
`timescale 1ns/1ps
`include "sce_consts.svh"

module sce_host_model
   import sce_pkg::*;
(
   input wire logic clk_sys,
   output sce_cmd_t cmd,
   input sce_rsp_t rsp
);

   // ---------------------------------------------------------------
   // Command issue
   // ---------------------------------------------------------------
   initial
   begin
      cmd = '0;
   end

   task automatic issue(input logic [`SCE_CODE_W-1:0] code, input int gap, output logic answered);
      int n;
      answered = 1'b0;
      repeat (gap) @(negedge clk_sys);
      cmd.valid <= 1'b1;
      cmd.code <= code;
      @(negedge clk_sys);
      // Idle code is inverted so a stale value never looks valid
      cmd.valid <= 1'b0;
      cmd.code <= ~code;
      // One command in flight; the next waits for ack or error
      for (n = 0; n < 8 && !answered; n++)
      begin
         @(negedge clk_sys);
         answered = (rsp.ack === 1'b1) || (rsp.err === 1'b1);
      end
   endtask : issue

endmodule : sce_host_model

// ### hw/sce_cmd_exec.sv
/*
 Scale command executor for codes 116 to 127: host port arbitration,
 state checks, action pulses, tare and inspection counters, display.
 Assumes all inputs come from logic on clk_sys; the weighing sequencer
 outside consumes the action pulses and reports cycle state.
*/
`timescale 1ns/1ps
`include "sce_consts.svh"

module sce_cmd_exec
   import sce_pkg::*;
#(
   parameter int unsigned TOTAL_HOLD_CYC = `SCE_TOTAL_HOLD_MS * `SCE_CLK_KHZ,
   parameter int unsigned LOG_STEP_CYC = `SCE_LOG_STEP_MS * `SCE_CLK_KHZ
)
(
   input wire logic clk_sys,
   input wire logic rst,
   input sce_cmd_t host_cmd [`SCE_NUM_HOSTS],
   output sce_rsp_t host_rsp [`SCE_NUM_HOSTS],
   input wire logic cycle_running,
   input wire logic automatic_totalizing_mode,
   input wire logic emptying,
   input wire logic cont_start,
   input wire logic tare_done,
   input wire logic insp_done,
   input wire logic reg_optimal,
   output sce_act_t act_q,
   output logic tare_due_q,
   output logic insp_due_q,
   output sce_disp_t disp_q
);

   localparam int N = `SCE_NUM_HOSTS;

   logic [N-1:0] grant;
   logic [N-1:0] pend_vec;
   logic [`SCE_CODE_W-1:0] code_arr [N];
   logic gvalid;
   logic [`SCE_CODE_W-1:0] gcode;
   logic cmd_ok;
   logic show_total, show_weight, show_log;
   logic set_tare, set_insp;
   sce_act_t act_d;

   // ---------------------------------------------------------------
   // Host ports
   // ---------------------------------------------------------------
   // A code is latched per port; a second one before the answer is
   // dropped, since hosts wait for the answer anyway.
   for (genvar i = 0; i < N; i++)
   begin : g_host
      logic pend_q, pend_d;
      logic [`SCE_CODE_W-1:0] code_q, code_d;
      sce_rsp_t rsp_q, rsp_d;

      always_comb
      begin
         pend_d = pend_q;
         code_d = code_q;
         rsp_d.ack = grant[i] & cmd_ok;
         rsp_d.err = grant[i] & ~cmd_ok;
         if (grant[i])
            pend_d = 1'b0;
         if (host_cmd[i].valid && !pend_q)
         begin
            pend_d = 1'b1;
            code_d = host_cmd[i].code;
         end
      end

      always_ff @(posedge clk_sys)
      begin
         if (rst)
         begin
            pend_q <= 1'b0;
            code_q <= '0;
            rsp_q <= '0;
         end
         else
         begin
            pend_q <= pend_d;
            code_q <= code_d;
            rsp_q <= rsp_d;
         end
      end

      assign pend_vec[i] = pend_q;
      assign code_arr[i] = code_q;
      assign host_rsp[i] = rsp_q;
   end

   // Lowest port wins; others wait a cycle
   always_comb
   begin
      grant = '0;
      gvalid = 1'b0;
      gcode = '0;
      for (int i = 0; i < N; i++)
      begin
         if (pend_vec[i] && !gvalid)
         begin
            grant[i] = 1'b1;
            gvalid = 1'b1;
            gcode = code_arr[i];
         end
      end
   end

   // ---------------------------------------------------------------
   // Decode and state check
   // ---------------------------------------------------------------
   always_comb
   begin
      cmd_ok = 1'b0;
      act_d = '0;
      show_total = 1'b0;
      show_weight = 1'b0;
      show_log = 1'b0;
      set_tare = 1'b0;
      set_insp = 1'b0;
      if (gvalid)
      begin
         unique case (gcode)
            `SCE_CMD_DEL_STATS:
            begin
               cmd_ok = !cycle_running;
               act_d.clr_stats = cmd_ok;
            end
            `SCE_CMD_SHOW_TOTAL:
            begin
               cmd_ok = 1'b1;
               show_total = 1'b1;
            end
            `SCE_CMD_EMPTY_OFF:
            begin
               cmd_ok = !cycle_running;
               act_d.empty_off = cmd_ok;
            end
            `SCE_CMD_SINGLE_START:
            begin
               cmd_ok = !cycle_running;
               act_d.single_start = cmd_ok;
            end
            `SCE_CMD_FORCE_TARE:
            begin
               cmd_ok = 1'b1;
               set_tare = 1'b1;
            end
            `SCE_CMD_FORCE_INSP:
            begin
               cmd_ok = 1'b1;
               set_insp = 1'b1;
            end
            `SCE_CMD_RESID_EMPTY:
            begin
               cmd_ok = cycle_running;
               act_d.resid_empty = cmd_ok;
            end
            `SCE_CMD_SHOW_WEIGHT:
            begin
               cmd_ok = 1'b1;
               show_weight = 1'b1;
            end
            `SCE_CMD_SHOW_LOG:
            begin
               cmd_ok = 1'b1;
               show_log = 1'b1;
            end
            `SCE_CMD_FINISH_NO_EMPTY:
            begin
               cmd_ok = (cycle_running && automatic_totalizing_mode) || emptying;
               act_d.finish_no_empty = cmd_ok;
            end
            // Codes outside this set are refused
            default: cmd_ok = 1'b0;
         endcase
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         act_q <= '0;
      else
         act_q <= act_d;
   end

   // ---------------------------------------------------------------
   // Tare and inspection counters
   // ---------------------------------------------------------------
   logic force_tare_q, force_tare_d, force_insp_q, force_insp_d;
   logic insp_run_q, insp_run_d, start_evt;
   logic [`SCE_CNT_W-1:0] tare_cnt_q, tare_cnt_d, insp_cnt_q, insp_cnt_d;
   logic tare_due_d, insp_due_d;

   // Counters advance on single and continuous starts alike
   assign start_evt = act_q.single_start | cont_start;

   always_comb
   begin
      force_tare_d = force_tare_q;
      force_insp_d = force_insp_q;
      insp_run_d = insp_run_q;
      tare_cnt_d = tare_cnt_q;
      insp_cnt_d = insp_cnt_q;
      if (start_evt && tare_cnt_q != `SCE_TARE_INTERVAL)
         tare_cnt_d = tare_cnt_q + `SCE_CNT_W'(1);
      if (start_evt && insp_run_q && insp_cnt_q != `SCE_INSP_INTERVAL)
         insp_cnt_d = insp_cnt_q + `SCE_CNT_W'(1);
      if (tare_done)
      begin
         force_tare_d = 1'b0;
         tare_cnt_d = '0;
      end
      if (insp_done)
      begin
         force_insp_d = 1'b0;
         insp_cnt_d = '0;
         insp_run_d = 1'b0;
      end
      else if (reg_optimal)
         insp_run_d = 1'b1;
      // Set wins over a clear in the same cycle
      if (set_tare)
         force_tare_d = 1'b1;
      if (set_insp)
         force_insp_d = 1'b1;
      tare_due_d = force_tare_d || tare_cnt_d == `SCE_TARE_INTERVAL;
      insp_due_d = force_insp_d || insp_cnt_d == `SCE_INSP_INTERVAL;
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         force_tare_q <= 1'b0;
         force_insp_q <= 1'b0;
         insp_run_q <= 1'b1;
         tare_cnt_q <= '0;
         insp_cnt_q <= '0;
         tare_due_q <= 1'b0;
         insp_due_q <= 1'b0;
      end
      else
      begin
         force_tare_q <= force_tare_d;
         force_insp_q <= force_insp_d;
         insp_run_q <= insp_run_d;
         tare_cnt_q <= tare_cnt_d;
         insp_cnt_q <= insp_cnt_d;
         tare_due_q <= tare_due_d;
         insp_due_q <= insp_due_d;
      end
   end

   // ---------------------------------------------------------------
   // Display selection
   // ---------------------------------------------------------------
   sce_disp_seq #(
      .HOLD_CYC(TOTAL_HOLD_CYC),
      .STEP_CYC(LOG_STEP_CYC)
   ) u_disp (
      .clk_sys(clk_sys),
      .rst(rst),
      .show_total(show_total),
      .show_weight(show_weight),
      .show_log(show_log),
      .automatic_totalizing_mode(automatic_totalizing_mode),
      .disp_q(disp_q)
   );

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   sequence s_granted(logic [`SCE_CODE_W-1:0] c);
      gvalid && gcode == c;
   endsequence

   del_stats_a: assert property (s_granted(`SCE_CMD_DEL_STATS)
      |=> act_q.clr_stats == !$past(cycle_running))
      else $error("delete statistics state check wrong");
   empty_off_a: assert property (s_granted(`SCE_CMD_EMPTY_OFF)
      |=> act_q.empty_off == !$past(cycle_running))
      else $error("empty off state check wrong");
   resid_empty_a: assert property (s_granted(`SCE_CMD_RESID_EMPTY)
      |=> act_q.resid_empty == $past(cycle_running))
      else $error("residual emptying state check wrong");
   finish_cmd_a: assert property (s_granted(`SCE_CMD_FINISH_NO_EMPTY)
      |=> act_q.finish_no_empty == $past((cycle_running && automatic_totalizing_mode) || emptying))
      else $error("finish without emptying state check wrong");
   refused_cmd_a: assert property (host_rsp[0].err || host_rsp[1].err |-> act_q == '0)
      else $error("refused command still acted");
   port0_answer_a: assert property (pend_vec[0] |=> host_rsp[0].ack || host_rsp[0].err)
      else $error("port 0 not answered");
   port1_answer_a: assert property (pend_vec[1] |-> ##[1:2] host_rsp[1].ack || host_rsp[1].err)
      else $error("port 1 not answered");
   tare_clear_a: assert property (tare_done && !set_tare
      |=> !force_tare_q && tare_cnt_q == '0)
      else $error("tare counter not cleared");
   insp_hold_a: assert property (insp_done && !set_insp
      |=> !insp_run_q && insp_cnt_q == '0 && !force_insp_q)
      else $error("inspection counter not stopped");
   start_state_a: assert property (s_granted(`SCE_CMD_SINGLE_START) && cycle_running
      |=> !act_q.single_start && ($past(grant[0]) ? host_rsp[0].err : host_rsp[1].err))
      else $error("start accepted during cycle");

endmodule : sce_cmd_exec

// ### hw/sce_consts.svh
/*
 Constants of the scale command executor: host count, command codes,
 timing figures and counter limits.
 Assumes a 125 MHz system clock; included by package and modules.
*/
`ifndef SCE_CONSTS_SVH
`define SCE_CONSTS_SVH

// ---------------------------------------------------------------
// Host interfaces and command codes
// ---------------------------------------------------------------
`define SCE_NUM_HOSTS 2
`define SCE_CODE_W 8
`define SCE_CMD_DEL_STATS 8'h74
`define SCE_CMD_SHOW_TOTAL 8'h75
`define SCE_CMD_EMPTY_OFF 8'h76
`define SCE_CMD_SINGLE_START 8'h79
`define SCE_CMD_FORCE_TARE 8'h7A
`define SCE_CMD_FORCE_INSP 8'h7B
`define SCE_CMD_RESID_EMPTY 8'h7C
`define SCE_CMD_SHOW_WEIGHT 8'h7D
`define SCE_CMD_SHOW_LOG 8'h7E
`define SCE_CMD_FINISH_NO_EMPTY 8'h7F

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define SCE_CLK_KHZ 125000
`define SCE_TOTAL_HOLD_MS 5000
`define SCE_LOG_STEP_MS 4000
`define SCE_TMR_W 30
`define SCE_LOG_LAST 3'h4

// ---------------------------------------------------------------
// Tare and inspection intervals in starts
// ---------------------------------------------------------------
`define SCE_CNT_W 8
`define SCE_TARE_INTERVAL 8'h0A
`define SCE_INSP_INTERVAL 8'h14

`endif

// ### hw/sce_disp_seq.sv
/*
 Display selector: trade weight or total 1, the 5 s fallback and the
 timed walk through the log values.
 Assumes one-cycle command pulses on clk_sys from the executor.
*/
`timescale 1ns/1ps
`include "sce_consts.svh"

module sce_disp_seq
   import sce_pkg::*;
#(
   parameter int unsigned HOLD_CYC = 625000000,
   parameter int unsigned STEP_CYC = 500000000
)
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic show_total,
   input wire logic show_weight,
   input wire logic show_log,
   input wire logic automatic_totalizing_mode,
   output sce_disp_t disp_q
);

   sce_disp_t base_q, base_d, disp_d;
   logic seq_q, seq_d;
   logic [2:0] step_q, step_d;
   logic [`SCE_TMR_W-1:0] tmr_q, tmr_d;

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb
   begin
      base_d = base_q;
      seq_d = seq_q;
      step_d = step_q;
      tmr_d = tmr_q;
      if (show_log)
      begin
         seq_d = 1'b1;
         step_d = 3'h0;
         tmr_d = '0;
      end
      else if (seq_q)
      begin
         if (tmr_q == `SCE_TMR_W'(STEP_CYC - 1))
         begin
            // Timer restarts so a pending total 1 gets its full hold
            tmr_d = '0;
            if (step_q == `SCE_LOG_LAST)
               seq_d = 1'b0;
            else
               step_d = step_q + 3'h1;
         end
         else
            tmr_d = tmr_q + `SCE_TMR_W'(1);
      end
      else if (base_q == DISP_TOTAL1 && !automatic_totalizing_mode)
      begin
         if (tmr_q == `SCE_TMR_W'(HOLD_CYC - 1))
         begin
            base_d = DISP_WEIGHT;
            tmr_d = '0;
         end
         else
            tmr_d = tmr_q + `SCE_TMR_W'(1);
      end
      if (show_total)
      begin
         base_d = DISP_TOTAL1;
         if (!seq_d)
            tmr_d = '0;
      end
      if (show_weight)
         base_d = DISP_WEIGHT;
      if (seq_d)
         unique case (step_d)
            3'h0: disp_d = DISP_LOG_ID;
            3'h1: disp_d = DISP_GROSS_NET;
            3'h2: disp_d = DISP_TARE;
            3'h3: disp_d = DISP_LOG_TOTAL1;
            default: disp_d = DISP_SETPOINT;
         endcase
      else
         disp_d = base_d;
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         base_q <= DISP_WEIGHT;
         seq_q <= 1'b0;
         step_q <= 3'h0;
         tmr_q <= '0;
         disp_q <= DISP_WEIGHT;
      end
      else
      begin
         base_q <= base_d;
         seq_q <= seq_d;
         step_q <= step_d;
         tmr_q <= tmr_d;
         disp_q <= disp_d;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   awi_hold_a: assert property (disp_q == DISP_TOTAL1 && automatic_totalizing_mode
      && !show_weight && !show_log |=> disp_q == DISP_TOTAL1)
      else $error("total 1 left in totalizing mode");
   total_show_a: assert property (show_total && !show_weight && !show_log && !seq_q
      |=> disp_q == DISP_TOTAL1)
      else $error("total 1 not shown");
   weight_show_a: assert property (show_weight && !show_log && !seq_q
      |=> disp_q == DISP_WEIGHT)
      else $error("trade weight not restored");
   log_step_a: assert property (seq_q && !show_log && step_q < `SCE_LOG_LAST
      && tmr_q == `SCE_TMR_W'(STEP_CYC - 1) |=> step_q == $past(step_q) + 3'h1)
      else $error("log step did not advance");
   log_first_a: assert property (show_log |=> disp_q == DISP_LOG_ID)
      else $error("log walk did not start");

endmodule : sce_disp_seq

// ### hw/sce_pkg.sv
/*
 Types of the scale command executor.
 Assumes sce_consts.svh is on the include path.
*/
`include "sce_consts.svh"

package sce_pkg;

   typedef struct packed {
      logic valid;
      logic [`SCE_CODE_W-1:0] code;
   } sce_cmd_t;

   typedef struct packed {
      logic ack;
      logic err;
   } sce_rsp_t;

   typedef struct packed {
      logic clr_stats;
      logic empty_off;
      logic single_start;
      logic resid_empty;
      logic finish_no_empty;
   } sce_act_t;

   typedef enum logic [2:0] {
      DISP_WEIGHT,
      DISP_TOTAL1,
      DISP_LOG_ID,
      DISP_GROSS_NET,
      DISP_TARE,
      DISP_LOG_TOTAL1,
      DISP_SETPOINT
   } sce_disp_t;

endpackage : sce_pkg
